// file: ips_consts.svh
/*
 * Named constants of the IO-first power and reset sequence.
 * Assumes a 50 MHz reference clock; the millisecond and microsecond times convert to cycles with it, the edge and init counts are fixed.
 */
`ifndef IPS_CONSTS_SVH
`define IPS_CONSTS_SVH

`define IPS_CLK_MHZ        50
`define IPS_T_RAMP_MS      20
`define IPS_T_STEP_MS      100
`define IPS_T_STAB_US      100
`define IPS_T_INIT_US      16
`define IPS_POR_FULL_EDGES 24
`define IPS_CFG_SETUP      12
`define IPS_CFG_HOLD       12
`define IPS_INIT_MIN       10000
`define IPS_INIT_MAX       50000
`define IPS_CFG_W          16
`define IPS_CNT_W          23
`define IPS_ICNT_W         16
`define IPS_CNT_ZERO       23'h00_0000
`define IPS_ICNT_ZERO      16'h0000
`define IPS_CFG_ZERO       16'h0000

`endif

// file: ips_pkg.sv
/*
 * Types shared by both ends of the power and reset sequence.
 * Assumes ips_consts.svh is on the include path.
 */
`include "ips_consts.svh"

package ips_pkg;

   // Board sequencer phases.
   typedef enum logic [3:0] {
      SEQ_IDLE, SEQ_RAMP_1V8, SEQ_RAMP_SCAL, SEQ_RAMP_FIXED, SEQ_RAMP_1V5,
      SEQ_STAB, SEQ_INIT, SEQ_POR_HIGH, SEQ_CFG_HOLD, SEQ_WAIT_STAT,
      SEQ_DONE, SEQ_FAULT
   } ips_seq_state_type;

   // Device reset phases.
   typedef enum logic [2:0] {
      DEV_NO_IO, DEV_POR_HOLD, DEV_WAIT_FULL, DEV_FUSE_SCAN, DEV_READY
   } ips_dev_state_type;

endpackage

// file: ips_if.sv
/*
 * Board-level wires between the power sequencer and the processor.
 * Assumes both ends share i_ref_clk; the testbench instantiates it.
 */
`timescale 1ns/1ns
`include "ips_consts.svh"

interface ips_if;
   logic                  io_supply_1v8_ok;
   logic                  core_scalable_supply_ok;
   logic                  clk_run;
   logic                  por_n;
   logic                  warm_reset_n;
   logic                  full_reset_in_n;
   logic [`IPS_CFG_W-1:0] boot_cfg;
   logic                  boot_cfg_oe;
   logic                  reset_status_out;

   // Processor end.
   modport dev (
      input  io_supply_1v8_ok,
      input  core_scalable_supply_ok,
      input  clk_run,
      input  por_n,
      input  warm_reset_n,
      input  full_reset_in_n,
      input  boot_cfg,
      input  boot_cfg_oe,
      output reset_status_out
   );

   // Board sequencer end.
   modport seq (
      output io_supply_1v8_ok,
      output core_scalable_supply_ok,
      output clk_run,
      output por_n,
      output warm_reset_n,
      output full_reset_in_n,
      output boot_cfg,
      output boot_cfg_oe,
      input  reset_status_out
   );
endinterface

// file: ips_device.sv
/*
 * Processor end: core reset hold, reset status output and fuse scan start.
 * Assumes the board keeps its side of the sequence on the shared wires.
 */
`timescale 1ns/1ns
`include "ips_consts.svh"

module ips_device #(
   parameter int INIT_CYCLES = `IPS_INIT_MIN
) (
   // Clock and reset.
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_rst_n,
   // Board link.
   ips_if.dev                         link,
   // Internal reset outputs.
   output logic                       o_core_rst,
   output logic                       o_fuse_rst,
   output logic [`IPS_CFG_W-1:0]      o_boot_cfg,
   output logic                       o_ready
);

   typedef struct packed {
      ips_pkg::ips_dev_state_type st;
      logic [`IPS_ICNT_W-1:0]     cnt;
      logic                       full_d;
      logic                       core_rst;
      logic                       fuse_rst;
      logic                       stat;
      logic [`IPS_CFG_W-1:0]      cfg;
   } ips_dev_reg_type;

   ips_dev_reg_type dev_r;
   ips_dev_reg_type dev_nxt;

   // Next-state logic of the reset phases.
   always_comb begin
      dev_nxt        = dev_r;
      dev_nxt.full_d = link.full_reset_in_n;
      unique case (dev_r.st)
         ips_pkg::DEV_NO_IO: begin
            dev_nxt.stat     = 1'b0;
            dev_nxt.core_rst = 1'b1;
            dev_nxt.fuse_rst = 1'b1;
            if (link.io_supply_1v8_ok) begin
               dev_nxt.st = ips_pkg::DEV_POR_HOLD;
            end
         end
         ips_pkg::DEV_POR_HOLD: begin
            dev_nxt.core_rst = 1'b1;
            if (link.por_n) begin
               dev_nxt.st = ips_pkg::DEV_WAIT_FULL;
            end
         end
         ips_pkg::DEV_WAIT_FULL: begin
            // Boot straps are caught on the full reset rising edge.
            if (link.full_reset_in_n && !dev_r.full_d) begin
               dev_nxt.fuse_rst = 1'b0;
               dev_nxt.core_rst = 1'b0;
               dev_nxt.cfg      = link.boot_cfg_oe ? link.boot_cfg
                                                   : `IPS_CFG_ZERO;
               dev_nxt.cnt      = `IPS_ICNT_ZERO;
               dev_nxt.st       = ips_pkg::DEV_FUSE_SCAN;
            end
         end
         ips_pkg::DEV_FUSE_SCAN: begin
            dev_nxt.cnt = dev_r.cnt + 1'b1;
            if (dev_r.cnt == `IPS_ICNT_W'(INIT_CYCLES - 1)) begin
               dev_nxt.stat = 1'b1;
               dev_nxt.st   = ips_pkg::DEV_READY;
            end
         end
         ips_pkg::DEV_READY: begin
            dev_nxt.stat = 1'b1;
         end
      endcase
      // Losing the IO rail or power-on reset restarts everything but the caught straps.
      if (!link.io_supply_1v8_ok) begin
         dev_nxt.st       = ips_pkg::DEV_NO_IO;
         dev_nxt.stat     = 1'b0;
         dev_nxt.core_rst = 1'b1;
         dev_nxt.fuse_rst = 1'b1;
      end else if (!link.por_n) begin
         dev_nxt.st       = ips_pkg::DEV_POR_HOLD;
         dev_nxt.stat     = 1'b0;
         dev_nxt.core_rst = 1'b1;
         dev_nxt.fuse_rst = 1'b1;
      end
   end

   // State register.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         dev_r <= '{st: ips_pkg::DEV_NO_IO, cnt: `IPS_ICNT_ZERO,
                    full_d: 1'b0, core_rst: 1'b1, fuse_rst: 1'b1,
                    stat: 1'b0, cfg: `IPS_CFG_ZERO};
      end else begin
         dev_r <= dev_nxt;
      end
   end

   // The core reset also follows power-on reset directly, so no edge is
   // needed before the core is held once the core rail is up.
   assign o_core_rst            = dev_r.core_rst | ~link.por_n;
   assign o_fuse_rst            = dev_r.fuse_rst;
   assign o_boot_cfg            = dev_r.cfg;
   assign o_ready               = dev_r.stat;
   assign link.reset_status_out = dev_r.stat;

endmodule

// file: ips_sequencer.sv
/*
 * Board end: orders the supply rails, enables the clocks and times the
 * power-on reset, full reset and boot straps by counting clock edges.
 * Assumes rail power-good inputs synchronous to i_ref_clk.
 */
`timescale 1ns/1ns
`include "ips_consts.svh"

module ips_sequencer #(
   parameter int RAMP_CYCLES = `IPS_T_RAMP_MS * `IPS_CLK_MHZ * 1000,
   parameter int STEP_CYCLES = `IPS_T_STEP_MS * `IPS_CLK_MHZ * 1000,
   parameter int STAB_CYCLES = `IPS_T_STAB_US * `IPS_CLK_MHZ,
   parameter int STAT_CYCLES = `IPS_INIT_MAX
) (
   // Clock and reset.
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_rst_n,
   // Control.
   input  wire logic                  i_start,
   input  wire logic [`IPS_CFG_W-1:0] i_boot_cfg,
   // Rail power-good inputs.
   input  wire logic                  i_pg_io_1v8,
   input  wire logic                  i_pg_core_scal,
   input  wire logic                  i_pg_core_fixed,
   input  wire logic                  i_pg_io_1v5,
   // Rail enables.
   output logic                       o_en_io_1v8,
   output logic                       o_en_core_scal,
   output logic                       o_en_core_fixed,
   output logic                       o_en_io_1v5,
   output logic                       o_clk_drv_en,
   // Status.
   output logic                       o_done,
   output logic                       o_fault,
   // Device link.
   ips_if.seq                         link
);

   localparam int INIT_CYCLES = `IPS_T_INIT_US * `IPS_CLK_MHZ;

   typedef struct packed {
      ips_pkg::ips_seq_state_type st;
      logic [`IPS_CNT_W-1:0]      cnt;
      logic                       en_1v8;
      logic                       en_scal;
      logic                       en_fixed;
      logic                       en_1v5;
      logic                       clk_en;
      logic                       por_n;
      logic                       warm_n;
      logic                       full_n;
      logic                       cfg_oe;
      logic [`IPS_CFG_W-1:0]      cfg;
      logic                       done;
      logic                       fault;
   } ips_seq_reg_type;

   ips_seq_reg_type seq_r;
   ips_seq_reg_type seq_nxt;
   logic            cnt_hit_ramp;
   logic            cnt_hit_step;

   // Timeout comparisons shared by the rail states.
   assign cnt_hit_ramp = seq_r.cnt == `IPS_CNT_W'(RAMP_CYCLES - 1);
   assign cnt_hit_step = seq_r.cnt == `IPS_CNT_W'(STEP_CYCLES - 1);

   // Next-state logic of the power-up sequence.
   always_comb begin
      seq_nxt     = seq_r;
      seq_nxt.cnt = seq_r.cnt + 1'b1;
      unique case (seq_r.st)
         ips_pkg::SEQ_IDLE: begin
            seq_nxt.cnt = `IPS_CNT_ZERO;
            if (i_start) begin
               seq_nxt.en_1v8 = 1'b1;
               seq_nxt.st     = ips_pkg::SEQ_RAMP_1V8;
            end
         end
         ips_pkg::SEQ_RAMP_1V8: begin
            if (i_pg_io_1v8) begin
               // Straps and warm reset wait for the IO rail.
               seq_nxt.warm_n  = 1'b1;
               seq_nxt.cfg_oe  = 1'b1;
               seq_nxt.en_scal = 1'b1;
               seq_nxt.cnt     = `IPS_CNT_ZERO;
               seq_nxt.st      = ips_pkg::SEQ_RAMP_SCAL;
            end else if (cnt_hit_ramp) begin
               seq_nxt.st = ips_pkg::SEQ_FAULT;
            end
         end
         ips_pkg::SEQ_RAMP_SCAL: begin
            if (i_pg_core_scal) begin
               // Fixed core rail only after the scalable one is valid,
               // so it can never overtake it.
               seq_nxt.en_fixed = 1'b1;
               seq_nxt.clk_en   = 1'b1;
               seq_nxt.cnt      = `IPS_CNT_ZERO;
               seq_nxt.st       = ips_pkg::SEQ_RAMP_FIXED;
            end else if (cnt_hit_step) begin
               seq_nxt.st = ips_pkg::SEQ_FAULT;
            end
         end
         ips_pkg::SEQ_RAMP_FIXED: begin
            if (i_pg_core_fixed) begin
               seq_nxt.en_1v5 = 1'b1;
               seq_nxt.cnt    = `IPS_CNT_ZERO;
               seq_nxt.st     = ips_pkg::SEQ_RAMP_1V5;
            end else if (cnt_hit_ramp) begin
               seq_nxt.st = ips_pkg::SEQ_FAULT;
            end
         end
         ips_pkg::SEQ_RAMP_1V5: begin
            if (i_pg_io_1v5) begin
               seq_nxt.cnt = `IPS_CNT_ZERO;
               seq_nxt.st  = ips_pkg::SEQ_STAB;
            end else if (cnt_hit_ramp) begin
               seq_nxt.st = ips_pkg::SEQ_FAULT;
            end
         end
         ips_pkg::SEQ_STAB: begin
            if (seq_r.cnt == `IPS_CNT_W'(STAB_CYCLES - 1)) begin
               seq_nxt.cnt = `IPS_CNT_ZERO;
               seq_nxt.st  = ips_pkg::SEQ_INIT;
            end
         end
         ips_pkg::SEQ_INIT: begin
            // Clock already runs here, so the device sees its periods.
            if (seq_r.cnt == `IPS_CNT_W'(INIT_CYCLES - 1)) begin
               seq_nxt.por_n = 1'b1;
               seq_nxt.cnt   = `IPS_CNT_ZERO;
               seq_nxt.st    = ips_pkg::SEQ_POR_HIGH;
            end
         end
         ips_pkg::SEQ_POR_HIGH: begin
            // Straps have stood since the IO rail, far beyond the setup.
            if (seq_r.cnt == `IPS_CNT_W'(`IPS_POR_FULL_EDGES - 1)) begin
               seq_nxt.full_n = 1'b1;
               seq_nxt.cnt    = `IPS_CNT_ZERO;
               seq_nxt.st     = ips_pkg::SEQ_CFG_HOLD;
            end
         end
         ips_pkg::SEQ_CFG_HOLD: begin
            if (seq_r.cnt == `IPS_CNT_W'(`IPS_CFG_HOLD - 1)) begin
               seq_nxt.cfg_oe = 1'b0;
               seq_nxt.st     = ips_pkg::SEQ_WAIT_STAT;
            end
         end
         ips_pkg::SEQ_WAIT_STAT: begin
            // Count runs on from the full reset rise.
            if (link.reset_status_out) begin
               seq_nxt.done = 1'b1;
               seq_nxt.st   = ips_pkg::SEQ_DONE;
            end else if (seq_r.cnt == `IPS_CNT_W'(STAT_CYCLES - 1)) begin
               seq_nxt.st = ips_pkg::SEQ_FAULT;
            end
         end
         ips_pkg::SEQ_DONE: begin
            seq_nxt.cnt = `IPS_CNT_ZERO;
         end
         ips_pkg::SEQ_FAULT: begin
            // A failed rail pulls power-on reset and full reset low and shuts
            // the rails, leaving the part held in reset.
            seq_nxt           = '0;
            seq_nxt.st        = ips_pkg::SEQ_FAULT;
            seq_nxt.fault     = 1'b1;
         end
      endcase
      // Straps leave through a register so the pins never follow a
      // glitch on the control input; they read zero while not driven.
      seq_nxt.cfg = seq_nxt.cfg_oe ? i_boot_cfg : `IPS_CFG_ZERO;
   end

   // State register.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         seq_r    <= '0;
         seq_r.st <= ips_pkg::SEQ_IDLE;
      end else begin
         seq_r <= seq_nxt;
      end
   end

   // Outputs straight from the state register, except the two rail-valid link signals gated by power-good.
   assign o_en_io_1v8                  = seq_r.en_1v8;
   assign o_en_core_scal               = seq_r.en_scal;
   assign o_en_core_fixed              = seq_r.en_fixed;
   assign o_en_io_1v5                  = seq_r.en_1v5;
   assign o_clk_drv_en                 = seq_r.clk_en;
   assign o_done                       = seq_r.done;
   assign o_fault                      = seq_r.fault;
   assign link.io_supply_1v8_ok        = i_pg_io_1v8 & seq_r.en_1v8;
   assign link.core_scalable_supply_ok = i_pg_core_scal & seq_r.en_scal;
   assign link.clk_run                 = seq_r.clk_en;
   assign link.por_n                   = seq_r.por_n;
   assign link.warm_reset_n            = seq_r.warm_n;
   assign link.full_reset_in_n         = seq_r.full_n;
   assign link.boot_cfg                = seq_r.cfg;
   assign link.boot_cfg_oe             = seq_r.cfg_oe;

endmodule

// file: ips_assertions.sv
/* Timing checks on the board link of the power and reset sequence.
   Assumes it stands beside the link interface, sharing i_ref_clk. */
`timescale 1ns/1ns
`include "ips_consts.svh"

module ips_assertions #(
   parameter int INIT_CYCLES = `IPS_INIT_MIN
) (
   // Clock and reset.
   input wire logic                  i_ref_clk,
   input wire logic                  i_rst_n,
   // Link signals.
   input wire logic                  io_supply_1v8_ok,
   input wire logic                  core_scalable_supply_ok,
   input wire logic                  clk_run,
   input wire logic                  por_n,
   input wire logic                  warm_reset_n,
   input wire logic                  full_reset_in_n,
   input wire logic [`IPS_CFG_W-1:0] boot_cfg,
   input wire logic                  boot_cfg_oe,
   input wire logic                  reset_status_out
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   // Saturating counts of how long each level has stood high.
   logic [15:0] por_cnt_r, full_cnt_r, oe_cnt_r, clk_cnt_r;

   function automatic logic [15:0] bump(logic [15:0] c, logic on);
      return !on ? 16'h0000 : (c == 16'hffff) ? c : c + 16'h0001;
   endfunction

   // Saturation keeps long runs from wrapping back into a legal window.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         por_cnt_r  <= 16'h0000;
         full_cnt_r <= 16'h0000;
         oe_cnt_r   <= 16'h0000;
         clk_cnt_r  <= 16'h0000;
      end else begin
         por_cnt_r  <= bump(por_cnt_r, por_n);
         full_cnt_r <= bump(full_cnt_r, full_reset_in_n);
         oe_cnt_r   <= bump(oe_cnt_r, boot_cfg_oe);
         clk_cnt_r  <= bump(clk_cnt_r, clk_run);
      end
   end

   a_pins_before_io: assert property (!io_supply_1v8_ok |->
      !por_n && !full_reset_in_n && boot_cfg == 16'h0000)
      else $error("pin high before the IO rail is valid");
   a_warm_after_io: assert property (warm_reset_n |->
      io_supply_1v8_ok) else $error("warm reset released early");
   a_por_core_low: assert property (!core_scalable_supply_ok |->
      !por_n) else $error("power-on reset high without core rail");
   a_clk_after_core: assert property (clk_run |->
      core_scalable_supply_ok) else $error("clocks before core rail");
   a_status_por_low: assert property (!por_n |=>
      !reset_status_out) else $error("status high in power-on reset");
   a_clk_before_por: assert property ($rose(por_n) |->
      clk_cnt_r >= `IPS_T_INIT_US * `IPS_CLK_MHZ)
      else $error("clock too short before por");
   a_full_quiet_start: assert property ($rose(por_n) |->
      !full_reset_in_n [*8]) else $error("full reset rose too soon");
   a_full_hold_edges: assert property ($rose(full_reset_in_n) |->
      por_cnt_r >= `IPS_POR_FULL_EDGES)
      else $error("full reset held too briefly");
   a_cfg_setup_edges: assert property ($rose(full_reset_in_n) |->
      oe_cnt_r >= `IPS_CFG_SETUP) else $error("straps not set up in time");
   a_cfg_hold_edges: assert property (
      $fell(boot_cfg_oe) && full_reset_in_n |-> full_cnt_r >= `IPS_CFG_HOLD)
      else $error("straps released too early");
   a_status_init_win: assert property ($rose(reset_status_out) |->
      full_cnt_r >= INIT_CYCLES && full_cnt_r <= INIT_CYCLES + 4)
      else $error("status rose outside its window");

   // Main scenarios reached.
   c_por_rise: cover property ($rose(por_n));
   c_full_rise: cover property ($rose(full_reset_in_n));
   c_status_rise: cover property ($rose(reset_status_out));
endmodule

// file: tb_io_first_power_reset_sequence.sv
/* Self-checking bench joining both ends of the sequence.
   Assumes the shortened counts set at the instances below. */
`timescale 1ns/1ns
`include "ips_consts.svh"

module tb_io_first_power_reset_sequence;
   localparam int INIT = 30;
   localparam int LIM  = 5000;
   logic                  clk, rst_n, start;
   logic [`IPS_CFG_W-1:0] cfg, dev_cfg;
   logic [`IPS_CFG_W-1:0] cfg_tab[3];
   logic [3:0]            en, pg;
   logic                  clk_drv, done, fault, core_rst, fuse_rst, ready;
   int                    num_errors, n_compared, stuck, n;
   int                    dly[4];

   ips_if u_ips_if();
   ips_sequencer #(.RAMP_CYCLES(50), .STEP_CYCLES(80), .STAB_CYCLES(20),
      .STAT_CYCLES(200)) u_ips_sequencer (.i_ref_clk(clk), .i_rst_n(rst_n),
      .i_start(start), .i_boot_cfg(cfg), .i_pg_io_1v8(pg[0]),
      .i_pg_core_scal(pg[1]), .i_pg_core_fixed(pg[2]), .i_pg_io_1v5(pg[3]),
      .o_en_io_1v8(en[0]), .o_en_core_scal(en[1]), .o_en_core_fixed(en[2]),
      .o_en_io_1v5(en[3]), .o_clk_drv_en(clk_drv), .o_done(done),
      .o_fault(fault), .link(u_ips_if.seq));
   ips_device #(.INIT_CYCLES(INIT)) u_ips_device (.i_ref_clk(clk),
      .i_rst_n(rst_n), .link(u_ips_if.dev), .o_core_rst(core_rst),
      .o_fuse_rst(fuse_rst), .o_boot_cfg(dev_cfg), .o_ready(ready));
   ips_assertions #(.INIT_CYCLES(INIT)) u_ips_assertions (.i_ref_clk(clk),
      .i_rst_n(rst_n), .io_supply_1v8_ok(u_ips_if.io_supply_1v8_ok),
      .core_scalable_supply_ok(u_ips_if.core_scalable_supply_ok),
      .clk_run(u_ips_if.clk_run), .por_n(u_ips_if.por_n),
      .warm_reset_n(u_ips_if.warm_reset_n),
      .full_reset_in_n(u_ips_if.full_reset_in_n),
      .boot_cfg(u_ips_if.boot_cfg), .boot_cfg_oe(u_ips_if.boot_cfg_oe),
      .reset_status_out(u_ips_if.reset_status_out));

   // Clock at 50 MHz.
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Rails come good a random 2 to 22 cycles after enable; one may hang.
   always @(posedge clk) begin
      for (int k = 0; k < 4; k++) begin
         if (!en[k]) begin
            pg[k]  <= 1'b0;
            dly[k] <= 1 + $urandom_range(0, 20);
         end else if (dly[k] == 0) begin
            pg[k] <= (k != stuck);
         end else begin
            dly[k] <= dly[k] - 1;
         end
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   function automatic logic sig(input int w);
      case (w)
         0: return u_ips_if.io_supply_1v8_ok;
         1: return u_ips_if.por_n;
         2: return u_ips_if.full_reset_in_n;
         3: return u_ips_if.reset_status_out;
         4: return done;
         default: return fault;
      endcase
   endfunction

   // Counts settled cycles until the chosen signal is high, bounded.
   task automatic wait_for(input int w);
      n = 0;
      while (sig(w) !== 1'b1 && n < LIM) begin
         @(negedge clk);
         n++;
      end
      if (n >= LIM) num_errors++;
   endtask

   task automatic start_seq();
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
   endtask

   task automatic run_one(input logic [`IPS_CFG_W-1:0] c);
      start_seq();
      cfg <= c;
      wait_for(0);
      check(en[3:1], 3'b000);
      check(core_rst, 1'b1);
      check(u_ips_if.reset_status_out, 1'b0);
      wait_for(1);
      check(u_ips_if.boot_cfg, c);
      check(clk_drv, 1'b1);
      check(en, 4'hf);
      wait_for(2);
      check(n, 24);
      repeat (2) @(negedge clk);
      check(fuse_rst, 1'b0);
      check(dev_cfg, c);
      wait_for(3);
      check(n >= INIT - 2 && n <= INIT + 2, 1'b1);
      wait_for(4);
      check(fault, 1'b0);
      check({ready, core_rst, u_ips_if.boot_cfg_oe}, 3'b100);
   endtask

   task automatic give_verdict();
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Long enough for three sequences of about a thousand cycles and four short fault runs.
   initial begin
      repeat (40000) @(posedge clk);
      num_errors++;
      give_verdict();
   end

   initial begin
      rst_n = 1'b0;
      start = 1'b0;
      cfg = 16'h0000;
      pg = 4'h0;
      stuck = -1;
      num_errors = 0;
      n_compared = 0;
      void'($urandom(3439));
      cfg_tab = '{16'hffff, 16'h0000, 16'($urandom)};
      foreach (cfg_tab[i]) run_one(cfg_tab[i]);
      // A hung rail at each step must end in a latched fault.
      for (int k = 0; k < 4; k++) begin
         stuck = k;
         start_seq();
         wait_for(5);
         check({en, u_ips_if.por_n, fault}, 6'b000001);
      end
      give_verdict();
   end
endmodule
